/* acq_conv_timer.sv */
/*
  Divided conversion clock and conversion sequencer.
  Assumes the conversion clock source level is synchronous to clock_i and
  slower than half the system clock.
*/
`timescale 1ns/1ps

module acq_conv_timer #(
  parameter int CONV_CYCLES = 16
) (
  input  wire logic       clock_i,
  input  wire logic       rst_i,
  input  wire logic       src_clk_i,
  input  wire logic [1:0] div_sel_i,
  input  wire logic       start_req_i,
  output logic            divided_conversion_clock_o,
  output logic            conv_start_o,
  output logic            busy_o
);
  import acq_pkg::*;

  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_CONV} acq_conv_e;

  localparam int CNT_W = $clog2(CONV_CYCLES + 1);

  logic             src_q, src_d;
  logic [2:0]       div_q, div_d;
  logic             divided_conversion_clock_q, divided_conversion_clock_d;
  logic             divided_conversion_clock_lvl;
  logic             dfall;
  acq_conv_e        st_q, st_d;
  logic [1:0]       falls_q, falls_d;
  logic [CNT_W-1:0] left_q, left_d;
  logic             start_q, start_d;

  // divided clock level follows the counter of source rising edges, or the source itself when dividing by 1
  always_comb begin
    src_d = src_clk_i;
    div_d = div_q;
    if (src_clk_i && !src_q) begin
      div_d = div_q + 3'h1;
    end
    case (div_sel_i)
      DIV_BY_1: divided_conversion_clock_lvl = src_clk_i;
      DIV_BY_2: divided_conversion_clock_lvl = div_q[0];
      DIV_BY_4: divided_conversion_clock_lvl = div_q[1];
      DIV_BY_8: divided_conversion_clock_lvl = div_q[2];
      default:  divided_conversion_clock_lvl = src_clk_i;
    endcase
    divided_conversion_clock_d = divided_conversion_clock_lvl;
    dfall  = divided_conversion_clock_q && !divided_conversion_clock_lvl;
  end

  always_comb begin
    st_d    = st_q;
    falls_d = falls_q;
    left_d  = left_q;
    start_d = 1'b0;
    case (st_q)
      ST_IDLE: begin
        // a start while busy is dropped; the running conversion finishes
        if (start_req_i) begin
          st_d    = ST_WAIT;
          falls_d = 2'h0;
        end
      end
      ST_WAIT: begin
        if (dfall) begin
          falls_d = falls_q + 2'h1;
          if (falls_q + 2'h1 == START_FALLS) begin
            st_d    = ST_CONV;
            left_d  = CNT_W'(CONV_CYCLES);
            start_d = 1'b1;
          end
        end
      end
      ST_CONV: begin
        if (dfall) begin
          left_d = left_q - CNT_W'(1);
          if (left_q == CNT_W'(1)) begin
            st_d = ST_IDLE;
          end
        end
      end
      default: st_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      src_q   <= 1'b0;
      div_q   <= 3'h0;
      divided_conversion_clock_q  <= 1'b0;
      st_q    <= ST_IDLE;
      falls_q <= 2'h0;
      left_q  <= '0;
      start_q <= 1'b0;
    end else begin
      src_q   <= src_d;
      div_q   <= div_d;
      divided_conversion_clock_q  <= divided_conversion_clock_d;
      st_q    <= st_d;
      falls_q <= falls_d;
      left_q  <= left_d;
      start_q <= start_d;
    end
  end

  assign divided_conversion_clock_o       = divided_conversion_clock_q;
  assign conv_start_o = start_q;
  assign busy_o       = (st_q == ST_CONV);

endmodule : acq_conv_timer

/* acq_ctrl_monitor.sv */
/* Port checker for acq_ctrl_regs.
   Assumes a bind onto every instance of that module. */
`timescale 1ns/1ps
module acq_ctrl_monitor #(
  parameter int CONV_CYCLES = 16
) (
  input wire logic                       clock_i,
  input wire logic                       rst_i,
  input wire logic                       wr_en_i,
  input wire logic                       rd_en_i,
  input wire logic [acq_pkg::ADDR_W-1:0] addr_i,
  input wire logic [acq_pkg::DATA_W-1:0] wr_data_i,
  input wire logic [acq_pkg::DATA_W-1:0] rd_data_o,
  input wire logic                       rd_valid_o,
  input wire logic [acq_pkg::PIN_N-1:0]  port_pin_i,
  input wire logic [acq_pkg::PIN_N-1:0]  port_pin_o,
  input wire logic [acq_pkg::PIN_N-1:0]  port_pin_oe_n_o,
  input wire logic                       conv_clk_pin_oe_n_o,
  input wire logic [acq_pkg::GAIN_W-1:0] gain_select_o,
  input wire logic [4:0]                 gain_value_o,
  input wire logic [acq_pkg::CHAN_W-1:0] channel_select_o,
  input wire logic                       mux_polarity_swap_o,
  input wire logic                       mux_differential_o,
  input wire logic                       osc_enable_pin_i,
  input wire logic                       osc_run_o,
  input wire logic                       ref_clk_o,
  input wire logic                       divided_conversion_clock_o,
  input wire logic                       ref_power_o,
  input wire logic                       buf_power_o,
  input wire acq_pkg::acq_vref_e         vref_select_o,
  input wire logic                       conv_start_o,
  input wire logic                       busy_o
);
  import acq_pkg::*;
  localparam logic [4:0] GAINS [8] = '{5'h01, 5'h02, 5'h04, 5'h05, 5'h08, 5'h0A, 5'h10, 5'h14};
  logic rd_port;
  logic wr_port;
  logic wr_cfg;
  assign rd_port = rd_en_i && addr_i == REG_PORT_LEVEL;
  assign wr_port = wr_en_i && addr_i == REG_PORT_LEVEL;
  assign wr_cfg = wr_en_i && addr_i == REG_REF_OSC;
  logic      wr_dir;
  logic      osc_want;
  acq_vref_e exp_vref;
  assign wr_dir   = wr_en_i && addr_i == REG_PORT_DIR;
  assign osc_want = wr_data_i[4] || (wr_data_i[5] && wr_data_i[3]);
  assign exp_vref = wr_data_i[0] ? ACQ_VREF_1V15 : wr_data_i[1] ? ACQ_VREF_2V048 : ACQ_VREF_2V5;
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);

  AST_RD_ANSWER: assert property (rd_en_i |=> rd_valid_o)
    else $error("read strobe got no answer");
  AST_PIN_READ: assert property (rd_port |=> rd_data_o[3:0] == $past(port_pin_i))
    else $error("port read differs from pin levels");
  AST_UNUSED_ZERO: assert property (rd_port |=> rd_data_o[6:4] == 3'h0)
    else $error("unused port bits not zero");
  AST_BUSY_READ: assert property (rd_port |=> rd_data_o[7] == $past(busy_o))
    else $error("busy bit in port read wrong");
  AST_DIR: assert property (wr_dir |=> port_pin_oe_n_o == ~$past(wr_data_i[3:0]))
    else $error("pin direction not as written");
  AST_OUT_LATCH: assert property (wr_port |=> port_pin_o == $past(wr_data_i[3:0]))
    else $error("output latch not as written");
  AST_OSC_PIN: assert property (
    wr_cfg |=> conv_clk_pin_oe_n_o == !$past(wr_data_i[4]))
    else $error("clock pin direction wrong");
  AST_POWER: assert property (
    wr_cfg |=> {ref_power_o, buf_power_o} == $past(wr_data_i[3:2]))
    else $error("power bits wrong");
  AST_VREF: assert property (wr_cfg |=> vref_select_o == $past(exp_vref))
    else $error("reference selection wrong");
  AST_GAIN: assert property (gain_value_o == GAINS[gain_select_o])
    else $error("gain decode wrong");
  AST_SWAP: assert property (
    mux_polarity_swap_o == (!channel_select_o[3] && channel_select_o[2]))
    else $error("polarity swap wrong");
  AST_DIFF: assert property (mux_differential_o == !channel_select_o[3])
    else $error("differential select wrong");
  AST_OSC_RUN: assert property (
    wr_cfg |=> osc_run_o == ($past(osc_want) || osc_enable_pin_i))
    else $error("oscillator run state wrong");
  AST_REF_CLK: assert property (wr_cfg && !wr_data_i[5] |=> ref_clk_o == divided_conversion_clock_o)
    else $error("reference clock not from divided clock");
  AST_START_BUSY: assert property (conv_start_o |-> busy_o ##1 busy_o)
    else $error("busy not held at start");
  AST_BOOT: assert property ($fell(rst_i) |-> conv_clk_pin_oe_n_o)
    else $error("clock pin driven after reset");

  cover property (conv_start_o);
  cover property (wr_cfg && wr_data_i[5] && wr_data_i[3] && !wr_data_i[4]);
  cover property (rd_port);
  cover property (wr_cfg && wr_data_i[4]);
endmodule : acq_ctrl_monitor

bind acq_ctrl_regs acq_ctrl_monitor #(.CONV_CYCLES(CONV_CYCLES)) mon (
  .clock_i(clock_i), .rst_i(rst_i), .wr_en_i(wr_en_i), .rd_en_i(rd_en_i),
  .addr_i(addr_i), .wr_data_i(wr_data_i), .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o),
  .port_pin_i(port_pin_i), .port_pin_o(port_pin_o), .port_pin_oe_n_o(port_pin_oe_n_o),
  .conv_clk_pin_oe_n_o(conv_clk_pin_oe_n_o), .gain_select_o(gain_select_o),
  .gain_value_o(gain_value_o), .channel_select_o(channel_select_o),
  .mux_polarity_swap_o(mux_polarity_swap_o), .ref_power_o(ref_power_o),
  .mux_differential_o(mux_differential_o), .osc_enable_pin_i(osc_enable_pin_i),
  .osc_run_o(osc_run_o), .ref_clk_o(ref_clk_o), .divided_conversion_clock_o(divided_conversion_clock_o),
  .buf_power_o(buf_power_o), .vref_select_o(vref_select_o),
  .conv_start_o(conv_start_o), .busy_o(busy_o));

/* acq_ctrl_regs.sv */
/*
  Control registers of the acquisition converter: gain/mux, digital port
  level and direction, reference/oscillator configuration, plus the
  internal oscillator and conversion start timing.
  Assumes the serial framing logic outside delivers whole bytes as
  one-cycle write and read strobes synchronous to clock_i.
  Assumes the pin levels on port_pin_i are already resolved outside
  and synchronous to clock_i, and that the clock divide field is held
  by the converter control register logic elsewhere.
*/
`timescale 1ns/1ps

module acq_ctrl_regs #(
  parameter int CONV_CYCLES = 16
) (
  input  wire logic                        clock_i,
  input  wire logic                        rst_i,
  // byte-wide register port from the serial framing logic
  input  wire logic                        wr_en_i,
  input  wire logic                        rd_en_i,
  input  wire logic [acq_pkg::ADDR_W-1:0]  addr_i,
  input  wire logic [acq_pkg::DATA_W-1:0]  wr_data_i,
  output logic      [acq_pkg::DATA_W-1:0]  rd_data_o,
  output logic                             rd_valid_o,
  // clock divide field of the converter control register, held elsewhere
  input  wire logic [1:0]                  clk_div_sel_i,
  input  wire logic                        osc_enable_pin_i,
  // digital port pins
  input  wire logic [acq_pkg::PIN_N-1:0]   port_pin_i,
  output logic      [acq_pkg::PIN_N-1:0]   port_pin_o,
  output logic      [acq_pkg::PIN_N-1:0]   port_pin_oe_n_o,
  // conversion clock pin
  input  wire logic                        conv_clk_pin_i,
  output logic                             conv_clk_pin_o,
  output logic                             conv_clk_pin_oe_n_o,
  // analog front end controls
  output logic      [acq_pkg::GAIN_W-1:0]  gain_select_o,
  output logic      [4:0]                  gain_value_o,
  output logic      [acq_pkg::CHAN_W-1:0]  channel_select_o,
  output logic                             mux_differential_o,
  output logic                             mux_polarity_swap_o,
  output logic      [1:0]                  mux_pair_o,
  output logic                             ref_power_o,
  output logic                             buf_power_o,
  output acq_pkg::acq_vref_e               vref_select_o,
  output logic                             osc_run_o,
  output logic                             ref_clk_o,
  output logic                             divided_conversion_clock_o,
  output logic                             conv_start_o,
  output logic                             busy_o
);
  import acq_pkg::*;

  localparam logic [2:0] OSC_HALF_M1 = 3'(OSC_HALF - 1);

  logic [GAIN_W-1:0]    gain_q, gain_d;
  logic [CHAN_W-1:0]    chan_q, chan_d;
  logic [PIN_N-1:0]     latch_q, latch_d;
  logic [PIN_N-1:0]     dir_q, dir_d;
  logic [REF_OSC_W-1:0] cfg_q, cfg_d;
  logic [DATA_W-1:0]    rdat_q, rdat_d;
  logic                 rval_q, rval_d;
  logic                 start_req;

  logic [2:0]           osc_cnt_q, osc_cnt_d;
  logic                 osc_q, osc_d;
  logic                 osc_run;
  logic                 osc_drive;
  logic                 conv_src;
  logic                 busy;

  logic                 wr_gain, wr_level, wr_dir, wr_cfg;

  // analog front end fields and reference configuration
  always_comb begin
    wr_gain = wr_en_i && (addr_i == REG_GAIN_MUX);
    wr_cfg  = wr_en_i && (addr_i == REG_REF_OSC);
    gain_d  = gain_q;
    chan_d  = chan_q;
    cfg_d   = cfg_q;
    if (wr_gain) begin
      gain_d = wr_data_i[GAIN_LSB +: GAIN_W];
      chan_d = wr_data_i[CHAN_W-1:0];
    end
    // reserved upper bits are dropped, not stored
    if (wr_cfg) begin
      cfg_d = wr_data_i[REF_OSC_W-1:0];
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      gain_q <= 3'h0;
      chan_q <= RST_NIBBLE;
      cfg_q  <= RST_REF_OSC;
    end else begin
      gain_q <= gain_d;
      chan_q <= chan_d;
      cfg_q  <= cfg_d;
    end
  end

  // digital port latches, directions and the convert request
  always_comb begin
    wr_level = wr_en_i && (addr_i == REG_PORT_LEVEL);
    wr_dir   = wr_en_i && (addr_i == REG_PORT_DIR);
    latch_d  = latch_q;
    dir_d    = dir_q;
    // latches always take the low four bits of the byte; only driven pins show them
    if (wr_level) begin
      latch_d = wr_data_i[PIN_N-1:0];
    end
    // reserved upper bits are dropped, not stored
    if (wr_dir) begin
      dir_d = wr_data_i[PIN_N-1:0];
    end
    // a request while busy or waiting is dropped inside the timer
    start_req = (wr_gain || wr_level) && wr_data_i[BIT_CONVERT];
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      latch_q <= RST_NIBBLE;
      dir_q   <= RST_NIBBLE;
    end else begin
      latch_q <= latch_d;
      dir_q   <= dir_d;
    end
  end

  // register reads sample busy in the strobe cycle
  always_comb begin
    rval_d = rd_en_i;
    rdat_d = rdat_q;
    if (rd_en_i) begin
      case (addr_i)
        REG_GAIN_MUX:   rdat_d = {busy, gain_q, chan_q};
        // pin levels, not latches; bits six to four zero
        REG_PORT_LEVEL: rdat_d = {busy, 3'h0, port_pin_i};
        REG_PORT_DIR:   rdat_d = {4'h0, dir_q};
        REG_REF_OSC:    rdat_d = {2'h0, cfg_q};
        default:        rdat_d = RST_BYTE;
      endcase
    end
  end

  // read data holds until the next read strobe
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      rdat_q <= RST_BYTE;
      rval_q <= 1'b0;
    end else begin
      rdat_q <= rdat_d;
      rval_q <= rval_d;
    end
  end

  // internal oscillator: toggles every OSC_HALF system clocks
  always_comb begin
    osc_run = cfg_q[BIT_OSC_OUT] ||
              (cfg_q[BIT_OSC_SRC] && cfg_q[BIT_REF_PWR]) ||
              osc_enable_pin_i;
    osc_cnt_d = osc_cnt_q;
    osc_d     = osc_q;
    if (!osc_run) begin
      osc_cnt_d = 3'h0;
      osc_d     = 1'b0;
    end else if (osc_cnt_q == OSC_HALF_M1) begin
      osc_cnt_d = 3'h0;
      osc_d     = !osc_q;
    end else begin
      osc_cnt_d = osc_cnt_q + 3'h1;
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      osc_cnt_q <= 3'h0;
      osc_q     <= 1'b0;
    end else begin
      osc_cnt_q <= osc_cnt_d;
      osc_q     <= osc_d;
    end
  end

  // pin only driven by the enable bit, never by the source/power path
  assign osc_drive = cfg_q[BIT_OSC_OUT];
  // the pin level is only trusted while nothing here drives it
  assign conv_src  = osc_drive ? osc_q : conv_clk_pin_i;

  acq_conv_timer #(
    .CONV_CYCLES (CONV_CYCLES)
  ) u_timer (
    .clock_i      (clock_i),
    .rst_i        (rst_i),
    .src_clk_i    (conv_src),
    .div_sel_i    (clk_div_sel_i),
    .start_req_i  (start_req),
    .divided_conversion_clock_o       (divided_conversion_clock_o),
    .conv_start_o (conv_start_o),
    .busy_o       (busy)
  );

  // reference voltage select; bandgap bit overrides two-volt bit
  always_comb begin
    if (cfg_q[BIT_BANDGAP]) begin
      vref_select_o = ACQ_VREF_1V15;
    end else if (cfg_q[BIT_TWO_VOLT]) begin
      vref_select_o = ACQ_VREF_2V048;
    end else begin
      vref_select_o = ACQ_VREF_2V5;
    end
  end

  // gain code to gain figure
  always_comb begin
    case (gain_q)
      3'h0:    gain_value_o = 5'h01;
      3'h1:    gain_value_o = 5'h02;
      3'h2:    gain_value_o = 5'h04;
      3'h3:    gain_value_o = 5'h05;
      3'h4:    gain_value_o = 5'h08;
      3'h5:    gain_value_o = 5'h0A;
      3'h6:    gain_value_o = 5'h10;
      3'h7:    gain_value_o = 5'h14;
      default: gain_value_o = 5'h01;
    endcase
  end

  assign gain_select_o       = gain_q;
  assign channel_select_o    = chan_q;

  // channel decode; single-ended codes never swap polarity
  always_comb begin
    mux_differential_o  = !chan_q[CHAN_SE_BIT];
    mux_polarity_swap_o = 1'b0;
    mux_pair_o          = chan_q[1:0];
    if (!chan_q[CHAN_SE_BIT]) begin
      mux_polarity_swap_o = chan_q[CHAN_SWAP_BIT];
    end
  end

  // one driver cell per digital pin
  for (genvar p = 0; p < PIN_N; p++) begin : g_pin
    assign port_pin_o[p]      = latch_q[p];
    assign port_pin_oe_n_o[p] = !dir_q[p];
  end

  assign conv_clk_pin_o      = osc_q;
  assign conv_clk_pin_oe_n_o = !osc_drive;

  assign ref_power_o         = cfg_q[BIT_REF_PWR];
  assign buf_power_o         = cfg_q[BIT_BUF_PWR];
  assign osc_run_o           = osc_run;
  assign ref_clk_o           = cfg_q[BIT_OSC_SRC] ? osc_q : divided_conversion_clock_o;

  assign rd_data_o           = rdat_q;
  assign rd_valid_o          = rval_q;
  assign busy_o              = busy;

endmodule : acq_ctrl_regs

/* acq_host_model.sv */
/* Host side of the byte register port: one write or read at a time.
   Assumes the bench calls its tasks sequentially. */
`timescale 1ns/1ps
module acq_host_model (
  input  wire logic       clock_i,
  input  wire logic [7:0] rd_data_i,
  output logic            wr_en_o,
  output logic            rd_en_o,
  output logic [4:0]      addr_o,
  output logic [7:0]      wr_data_o
);
  import acq_pkg::*;
  initial begin
    wr_en_o = 1'b0;
    rd_en_o = 1'b0;
    addr_o = 5'h00;
    wr_data_o = 8'h00;
  end

  task automatic wr_byte(input logic [4:0] a, input logic [7:0] d);
    @(posedge clock_i);
    wr_en_o <= 1'b1;
    addr_o <= a;
    // reserved bits of the direction and reference/oscillator registers sent as zero
    wr_data_o <= (a == REG_PORT_DIR) ? {4'h0, d[3:0]} :
                 (a == REG_REF_OSC) ? {2'h0, d[5:0]} : d;
    @(posedge clock_i);
    wr_en_o <= 1'b0;
  endtask : wr_byte

  task automatic rd_byte(input logic [4:0] a, output logic [7:0] d);
    @(posedge clock_i);
    rd_en_o <= 1'b1;
    addr_o <= a;
    @(posedge clock_i);
    rd_en_o <= 1'b0;
    @(posedge clock_i);
    d = rd_data_i;
  endtask : rd_byte
endmodule : acq_host_model

/* acq_pkg.sv */
/*
  Shared constants for the acquisition control register bank: register
  indices, field positions, reset values, clock rates and encodings.
  Assumes a single 40 MHz system clock.
*/
package acq_pkg;

  localparam int          ADDR_W         = 5;
  localparam int          DATA_W         = 8;
  localparam int          PIN_N          = 4;

  // register indices as seen on the register port
  localparam logic [4:0]  REG_GAIN_MUX   = 5'h04;
  localparam logic [4:0]  REG_PORT_LEVEL = 5'h05;
  localparam logic [4:0]  REG_PORT_DIR   = 5'h06;
  localparam logic [4:0]  REG_REF_OSC    = 5'h07;

  // gain/mux and port-level register fields
  localparam int          BIT_CONVERT    = 7;
  localparam int          GAIN_LSB       = 4;
  localparam int          GAIN_W         = 3;
  localparam int          CHAN_W         = 4;
  localparam int          CHAN_SE_BIT    = 3;
  localparam int          CHAN_SWAP_BIT  = 2;

  // reference/oscillator register fields
  localparam int          BIT_OSC_SRC    = 5;
  localparam int          BIT_OSC_OUT    = 4;
  localparam int          BIT_REF_PWR    = 3;
  localparam int          BIT_BUF_PWR    = 2;
  localparam int          BIT_TWO_VOLT   = 1;
  localparam int          BIT_BANDGAP    = 0;
  localparam int          REF_OSC_W      = 6;

  localparam logic [7:0]  RST_BYTE       = 8'h00;
  localparam logic [3:0]  RST_NIBBLE     = 4'h0;
  localparam logic [5:0]  RST_REF_OSC    = 6'h00;

  // clock rates
  localparam int          SYS_CLK_HZ     = 40_000_000;
  localparam int          OSC_HZ         = 2_500_000;
  localparam int          OSC_HALF       = SYS_CLK_HZ / (2 * OSC_HZ);

  // clock divide field encodings
  localparam logic [1:0]  DIV_BY_1       = 2'h0;
  localparam logic [1:0]  DIV_BY_2       = 2'h1;
  localparam logic [1:0]  DIV_BY_4       = 2'h2;
  localparam logic [1:0]  DIV_BY_8       = 2'h3;

  // falling edges of the divided clock from write to start
  localparam logic [1:0]  START_FALLS    = 2'h2;

  // reference voltage selections
  typedef enum logic [1:0] {
    ACQ_VREF_2V5,
    ACQ_VREF_2V048,
    ACQ_VREF_1V15
  } acq_vref_e;

endpackage : acq_pkg

/* test_acq_ctrl_regs.sv */
/* Self-checking bench for acq_ctrl_regs driven by the host model.
   Assumes the package, model and monitor bind are compiled first. */
`timescale 1ns/1ps
module test_acq_ctrl_regs;
  import acq_pkg::*;
  localparam int CC = 2;
  localparam int DIVIDED_CONVERSION_CLOCK_P = 8; // source period 4 clocks, divide by 2
  localparam logic [4:0] GAINS [8] = '{5'h01, 5'h02, 5'h04, 5'h05, 5'h08, 5'h0A, 5'h10, 5'h14};
  typedef struct {logic [4:0] a; logic [7:0] d; logic [7:0] r;} acq_row_s;
  acq_row_s   rows [3] = '{'{5'h06, 8'hA5, 8'h05}, '{5'h1F, 8'hFF, 8'h00}, '{5'h07, 8'hEC, 8'h2C}};
  logic       clock_i, rst_i, wr_en, rd_en, conversion_clock_pin_in, conversion_clock_pin_out, conversion_clock_pin_oe_n, start, busy, osc_run;
  logic [4:0] addr, gain_value;
  logic [7:0] wr_data, rd_data, v;
  logic [3:0] ext_pins, pin_in, pin_out, pin_oe_n;
  logic [1:0] div_sel = 2'h1;
  logic [1:0] cc_cnt = 2'h0;
  acq_vref_e  vref;
  int         bad_count = 0;
  int         n_checks = 0;
  int         cyc = 0;

  acq_host_model host (.clock_i(clock_i), .rd_data_i(rd_data), .wr_en_o(wr_en),
    .rd_en_o(rd_en), .addr_o(addr), .wr_data_o(wr_data));
  acq_ctrl_regs #(.CONV_CYCLES(CC)) uut (.clock_i(clock_i), .rst_i(rst_i), .wr_en_i(wr_en),
    .rd_en_i(rd_en), .addr_i(addr), .wr_data_i(wr_data), .rd_data_o(rd_data),
    .rd_valid_o(), .clk_div_sel_i(div_sel), .osc_enable_pin_i(1'b0),
    .port_pin_i(pin_in), .port_pin_o(pin_out), .port_pin_oe_n_o(pin_oe_n),
    .conv_clk_pin_i(conversion_clock_pin_in), .conv_clk_pin_o(conversion_clock_pin_out), .conv_clk_pin_oe_n_o(conversion_clock_pin_oe_n),
    .gain_select_o(), .gain_value_o(gain_value), .channel_select_o(),
    .mux_differential_o(), .mux_polarity_swap_o(), .mux_pair_o(), .ref_power_o(),
    .buf_power_o(), .vref_select_o(vref), .osc_run_o(osc_run), .ref_clk_o(), .divided_conversion_clock_o(),
    .conv_start_o(start), .busy_o(busy));

  // each wire resolved from whoever drives it
  assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & ext_pins);
  assign conversion_clock_pin_in = conversion_clock_pin_oe_n ? cc_cnt[1] : conversion_clock_pin_out;

  initial begin
    clock_i = 1'b0;
    forever #12.5 clock_i = ~clock_i;
  end

  always @(posedge clock_i) begin
    cc_cnt <= cc_cnt + 2'h1;
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      bad_count++;
      give_verdict();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic give_verdict;
    if (bad_count == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : give_verdict

  task automatic conv(input logic [4:0] a);
    int n;
    n = 0;
    host.wr_byte(a, 8'h80);
    do begin
      @(posedge clock_i);
      #1;
      n++;
    end while (start !== 1'b1 && n < 40);
    chk(8'(n >= 9 && n <= 18), 8'h01);
    host.rd_byte(REG_PORT_LEVEL, v);
    chk(v[7], 1'b1);
    #1;
    n = 3;
    while (busy === 1'b1 && n < 99) begin
      n++;
      @(posedge clock_i);
      #1;
    end
    chk(8'(n), 8'(DIVIDED_CONVERSION_CLOCK_P * CC));
    host.rd_byte(REG_PORT_LEVEL, v);
    chk(v[7], 1'b0);
  endtask : conv

  initial begin
    int n;
    rst_i = 1'b1;
    ext_pins = 4'h0;
    repeat (4) @(posedge clock_i);
    rst_i <= 1'b0;
    foreach (rows[i]) begin
      host.wr_byte(rows[i].a, rows[i].d);
      host.rd_byte(rows[i].a, v);
      chk(v, rows[i].r);
    end
    chk(conversion_clock_pin_oe_n, 1'b1);
    chk(osc_run, 1'b1);
    for (int g = 0; g < 8; g++) begin
      host.wr_byte(REG_GAIN_MUX, {1'b0, 3'(g), 1'b0, 3'(g)});
      #1;
      chk(gain_value, GAINS[g]);
    end
    for (int r = 0; r < 4; r++) begin
      host.wr_byte(REG_REF_OSC, 8'(r));
      #1;
      chk(vref, r[0] ? ACQ_VREF_1V15 : r[1] ? ACQ_VREF_2V048 : ACQ_VREF_2V5);
    end
    host.wr_byte(REG_PORT_DIR, 8'h05);
    host.wr_byte(REG_PORT_LEVEL, 8'h7F);
    host.rd_byte(REG_PORT_LEVEL, v);
    chk(v, 8'h05);
    ext_pins <= 4'hA;
    host.wr_byte(REG_PORT_LEVEL, 8'h00);
    host.rd_byte(REG_PORT_LEVEL, v);
    chk(v, 8'h0A);
    chk(pin_oe_n, 4'hA);
    conv(REG_GAIN_MUX);
    conv(REG_PORT_LEVEL);
    host.wr_byte(REG_REF_OSC, 8'h30);
    #1;
    chk(conversion_clock_pin_oe_n, 1'b0);
    v[0] = conversion_clock_pin_out;
    n = 0;
    repeat (68) begin
      @(posedge clock_i);
      #1;
      if (conversion_clock_pin_out !== v[0]) n++;
      v[0] = conversion_clock_pin_out;
    end
    chk(8'(n), 8'h08);
    // second reset in mid-run must clear the oscillator bits again
    rst_i <= 1'b1;
    repeat (2) @(posedge clock_i);
    rst_i <= 1'b0;
    #1;
    chk(conversion_clock_pin_oe_n, 1'b1);
    chk(pin_oe_n, 4'hF);
    host.rd_byte(REG_REF_OSC, v);
    chk(v, RST_BYTE);
    give_verdict();
  end
endmodule : test_acq_ctrl_regs
